// >>> logic/period_timer_pre_postscaler.sv
// Period timer with prescaler, postscaler, register slave and interrupt
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module period_timer_pre_postscaler (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    input  wire period_timer_pkg::bus_req_s bus_req,
    output logic [7:0]                      rdata,
    output logic                            irq,
    output logic                            sync_serial_port_tick,
    output period_timer_pkg::time_base_s    pwm_time_base
);
    import period_timer_pkg::*;

    logic [7:0] timer_count;         // Counter value
    logic [7:0] period_match_value;  // Period register
    logic [6:0] timer_control;       // Implemented control bits
    logic [3:0] pre_cnt;             // Prescaler count
    logic [3:0] post_cnt;            // Postscaler count
    logic [7:0] irq_flags;           // Sticky status
    logic [7:0] irq_enables;         // Enable mask

    // Address decode
    wire wr_count   = bus_req.wr && (bus_req.addr == ADDR_COUNT);
    wire wr_control = bus_req.wr && (bus_req.addr == ADDR_CONTROL);
    wire wr_period  = bus_req.wr && (bus_req.addr == ADDR_PERIOD);
    wire wr_enables = bus_req.wr && (bus_req.addr == ADDR_ENABLES);
    wire wr_clr     = bus_req.wr && (bus_req.addr == ADDR_FLAG_CLR);

    // Control fields
    wire [1:0] prescale_select  = timer_control[PRE_LSB +: 2];
    wire       timer_run        = timer_control[RUN_BIT];
    wire [3:0] postscale_select = timer_control[POST_LSB +: 4];

    // Prescale decode
    // field to terminal count
    wire [3:0] pre_end = prescale_select[1] ? PRE_DIV16_END :
                         (prescale_select[0] ? PRE_DIV4_END : PRE_DIV1_END);
    wire pre_tick   = clk_en && timer_run && (pre_cnt == pre_end);
    wire match      = pre_tick && (timer_count == period_match_value);
    // postscale divides by code plus one
    wire post_tick  = match && (post_cnt == postscale_select);
    wire scaler_clr = wr_count || wr_control;

    // Prescaler counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Any reset empties the prescaler
            pre_cnt <= 4'h0;
        end else if (clk_en) begin
            // Clear on counter or control write or on terminal count
            if (scaler_clr || pre_tick) begin
                pre_cnt <= 4'h0;
            // Count instruction clocks while running
            end else if (timer_run) begin
                pre_cnt <= pre_cnt + 4'h1;
            end
        end
    end

    // Postscaler counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Any reset empties the postscaler
            post_cnt <= 4'h0;
        end else if (clk_en) begin
            // Clear on counter or control write or when the ratio is reached
            if (scaler_clr || post_tick) begin
                post_cnt <= 4'h0;
            // One step per period match
            end else if (match) begin
                post_cnt <= post_cnt + 4'h1;
            end
        end
    end

    // Counter: software write wins, control write leaves it alone
    // reset clears, write loads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_count <= COUNT_RESET;
        end else if (clk_en) begin
            // Software load has priority over counting
            if (wr_count) begin
                timer_count <= bus_req.wdata;
            // Wrap instead of advancing past the period
            end else if (match) begin
                timer_count <= 8'h00;
            // Plain increment on a prescaler tick
            end else if (pre_tick) begin
                timer_count <= timer_count + 8'h01;
            end
        end
    end

    // Period and control registers
    // period resets to all ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_match_value <= PERIOD_RESET;
            timer_control      <= CONTROL_RESET;
        end else if (clk_en) begin
            if (wr_period) begin
                period_match_value <= bus_req.wdata;
            end
            if (wr_control) begin
                timer_control <= bus_req.wdata[6:0];
            end
        end
    end

    // Interrupt flags and enables; set wins over clear
    // postscaled match sets sticky flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flags   <= 8'h00;
            irq_enables <= 8'h00;
        end else if (clk_en) begin
            // Clear only when no set arrives in the same cycle
            if (wr_clr && !post_tick) begin
                irq_flags[FLAG_BIT] <= irq_flags[FLAG_BIT] & ~bus_req.wdata[FLAG_BIT];
            end else if (post_tick) begin
                irq_flags[FLAG_BIT] <= 1'b1;
            end
            if (wr_enables) begin
                irq_enables <= bus_req.wdata & (8'h01 << FLAG_BIT);
            end
        end
    end

    // Read mux
    // bit 7 of control reads zero
    wire [7:0] read_mux =
        (bus_req.addr == ADDR_COUNT)   ? timer_count :
        (bus_req.addr == ADDR_CONTROL) ? ({1'b0, timer_control} & CONTROL_MASK) :
        (bus_req.addr == ADDR_PERIOD)  ? period_match_value :
        (bus_req.addr == ADDR_FLAGS)   ? irq_flags :
        (bus_req.addr == ADDR_ENABLES) ? irq_enables : 8'h00;

    // Read data register, one cycle after strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            rdata <= bus_req.rd ? read_mux : 8'h00;
        end
    end

    // Outputs
    assign irq = |(irq_flags & irq_enables);
    assign sync_serial_port_tick = match;
    assign pwm_time_base = '{count: timer_count, match: match};

    a_stop_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (!timer_run && !wr_count) |=> $stable(timer_count))
        else $error("Counter moved while stopped");
    a_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (match && !wr_count) |=> (timer_count == 8'h00))
        else $error("Counter did not wrap after match");
    a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        post_tick |=> irq_flags[FLAG_BIT])
        else $error("Flag not set by postscaler");
    a_ctrl_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_control && !pre_tick) |=> (timer_count == $past(timer_count)))
        else $error("Control write changed counter");
    a_scaler_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && scaler_clr) |=> (pre_cnt == 4'h0 && post_cnt == 4'h0))
        else $error("Scalers not cleared on write");
    a_bit7_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && bus_req.rd && bus_req.addr == ADDR_CONTROL) |=> !rdata[7])
        else $error("Control bit 7 read as one");
    a_pre_bound: assert property (@(posedge clk) disable iff (!rst_n)
        pre_cnt <= pre_end || $past(wr_control))
        else $error("Prescaler past terminal count");
    a_serial_tick: assert property (@(posedge clk) disable iff (!rst_n)
        sync_serial_port_tick |-> (timer_count == period_match_value))
        else $error("Serial tick without match");
    a_count_write: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && wr_count) |=> (timer_count == $past(bus_req.wdata)))
        else $error("Counter write lost");

    c_match: cover property (@(posedge clk) match);
    c_post16: cover property (@(posedge clk) post_tick && postscale_select == 4'hF);
    c_irq: cover property (@(posedge clk) $rose(irq));
    c_set_clr: cover property (@(posedge clk) post_tick && wr_clr);
    c_pre16: cover property (@(posedge clk) pre_tick && prescale_select[1]);

    // Further checks on freeze, scalers, registers and flags
    // The clock enable freezes every piece of state

    a_freeze_count: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(timer_count))
        else $error("Counter moved while clock enable low");

    a_freeze_flags: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(irq_flags))
        else $error("Flags moved while clock enable low");

    a_freeze_rdata: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(rdata))
        else $error("Read data moved while clock enable low");

    a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        (pre_tick && !match && !wr_count) |=> (timer_count == $past(timer_count) + 8'h01))
        else $error("Counter did not step by one");

    a_no_tick_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (!pre_tick && !wr_count) |=> $stable(timer_count))
        else $error("Counter moved without a tick");

    a_pre_restart: assert property (@(posedge clk) disable iff (!rst_n)
        pre_tick |=> (pre_cnt == 4'h0))
        else $error("Prescaler not restarted after tick");

    a_pre_div1: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && timer_run && prescale_select == 2'b00) |-> pre_tick)
        else $error("Divide by one missed a tick");

    a_pre_div4: assert property (@(posedge clk) disable iff (!rst_n)
        (prescale_select == 2'b01 && pre_cnt != PRE_DIV4_END) |-> !pre_tick)
        else $error("Divide by four ticked early");

    a_period_write: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && wr_period) |=> (period_match_value == $past(bus_req.wdata)))
        else $error("Period write lost");

    a_period_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_period |=> $stable(period_match_value))
        else $error("Period changed without a write");

    a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && wr_control) |=> (timer_control == $past(bus_req.wdata[6:0])))
        else $error("Control write lost");

    a_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_control |=> $stable(timer_control))
        else $error("Control changed without a write");

    a_stop_pre: assert property (@(posedge clk) disable iff (!rst_n)
        !timer_run |-> !pre_tick)
        else $error("Prescaler ticked while stopped");

    // serial tick needs a running timer
    a_tick_needs_run: assert property (@(posedge clk) disable iff (!rst_n)
        sync_serial_port_tick |-> timer_run)
        else $error("Serial tick while stopped");

    a_post_bound: assert property (@(posedge clk) disable iff (!rst_n)
        post_cnt <= postscale_select || $past(wr_control))
        else $error("Postscaler past its ratio");

    a_post_step: assert property (@(posedge clk) disable iff (!rst_n)
        (match && !post_tick && !scaler_clr) |=> (post_cnt == $past(post_cnt) + 4'h1))
        else $error("Postscaler did not step on match");

    a_post_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        post_tick |=> (post_cnt == 4'h0))
        else $error("Postscaler not restarted");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_flags[FLAG_BIT] && !wr_clr) |=> irq_flags[FLAG_BIT])
        else $error("Flag dropped without a clear");

    // only the postscaler sets the flag
    a_flag_source: assert property (@(posedge clk) disable iff (!rst_n)
        !post_tick |=> !$rose(irq_flags[FLAG_BIT]))
        else $error("Flag set without postscaler output");

    // clear works when no set competes
    a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && wr_clr && bus_req.wdata[FLAG_BIT] && !post_tick)
        |=> !irq_flags[FLAG_BIT])
        else $error("Flag clear ignored");

    a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && wr_enables) |=> (irq_enables[FLAG_BIT] == $past(bus_req.wdata[FLAG_BIT])))
        else $error("Enable write lost");

    a_unused_flags: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_flags & ~(8'h01 << FLAG_BIT)) == 8'h00)
        else $error("Unused status bit set");

    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !bus_req.rd) |=> (rdata == 8'h00))
        else $error("Read data without a read strobe");
endmodule

// >>> logic/period_timer_pkg.sv
// Package with register map, field layout, reset values and carrier types for the period timer
// Notes on behaviour
// - Counter counts up, wraps after period match
// - Instruction clock through 1:1/1:4/1:16 prescaler
// - Period register read/write, resets all ones
// - Counter read/write, resets to zero
// - Postscaled match sets sticky interrupt flag
// - Control bit 2 runs or stops counter
// - Scaler counts cleared on counter or control writes, reset
// - Control write leaves counter unchanged
// - Unscaled match pulse goes to serial port
// - Count and match feed PWM units
// - Control bit 7 reads as zero
package period_timer_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam logic [7:0]  ADDR_FLAGS     = 8'h0C;
    localparam logic [7:0]  ADDR_COUNT     = 8'h11;
    localparam logic [7:0]  ADDR_CONTROL   = 8'h12;
    localparam logic [7:0]  ADDR_ENABLES   = 8'h8C;
    localparam logic [7:0]  ADDR_PERIOD    = 8'h92;
    localparam logic [7:0]  ADDR_FLAG_CLR  = 8'h0D;
    localparam int          PRE_LSB        = 0;
    localparam int          RUN_BIT        = 2;
    localparam int          POST_LSB       = 3;
    localparam int          FLAG_BIT       = 1;
    localparam logic [7:0]  PERIOD_RESET   = 8'hFF;
    localparam logic [7:0]  COUNT_RESET    = 8'h00;
    localparam logic [6:0]  CONTROL_RESET  = 7'h00;
    localparam logic [7:0]  CONTROL_MASK   = 8'h7F;
    localparam logic [3:0]  PRE_DIV1_END   = 4'h0;
    localparam logic [3:0]  PRE_DIV4_END   = 4'h3;
    localparam logic [3:0]  PRE_DIV16_END  = 4'hF;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    // Time base handed to the PWM units
    typedef struct packed {
        logic [7:0] count;
        logic       match;
    } time_base_s;
endpackage

// >>> tb/tb_top.sv
// Self-checking bench for the period timer
`timescale 1ns/1ps
module tb_top;
    import period_timer_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       clk_en = 1'b1;
    bus_req_s   bus_req = '0;
    logic [7:0] rdata;
    logic       irq;
    logic       tick;
    time_base_s pwm_base;
    int         mismatches = 0;
    int         samples_checked = 0;
    int         n;
    int         k;
    logic [7:0] v;

    period_timer_pre_postscaler i_period_timer_pre_postscaler (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req), .rdata(rdata),
        .irq(irq), .sync_serial_port_tick(tick), .pwm_time_base(pwm_base));

    // 50 MHz clock
    initial forever #10 clk = ~clk;

    // Compare and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe, then an idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        @(posedge clk);
    endtask

    // Read strobe; data taken in the following cycle
    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 chk(name, rdata, exp);
        @(posedge clk);
    endtask

    // Verdict and end of run
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #200000;
        mismatches++;
        end_of_test;
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("count", ADDR_COUNT, 8'h00);
        rchk("control", ADDR_CONTROL, 8'h00);
        rchk("period", ADDR_PERIOD, 8'hFF);
        rchk("flags", ADDR_FLAGS, 8'h00);
        rchk("unmapped", 8'h20, 8'h00);
        wr(ADDR_CONTROL, 8'hFB);
        rchk("control", ADDR_CONTROL, 8'h7B);
        wr(ADDR_PERIOD, 8'h03);
        rchk("period", ADDR_PERIOD, 8'h03);
        // Run 1:1 and catch the wrap
        wr(ADDR_CONTROL, 8'h04);
        repeat (8) begin @(posedge clk); #1; if (tick) break; end
        chk("wrap_at", pwm_base.count, 8'h03);
        chk("match", {7'h00, pwm_base.match}, 8'h01);
        @(posedge clk);
        #1 chk("wrap", pwm_base.count, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk("tick", {7'h00, tick}, 8'h01);
        // Frozen while the clock enable is low
        @(posedge clk);
        clk_en <= 1'b0;
        #1 v = pwm_base.count;
        repeat (4) @(posedge clk);
        #1 chk("frozen", pwm_base.count, v);
        @(posedge clk);
        clk_en <= 1'b1;
        @(posedge clk);
        // Stopped timer keeps its count across a control write
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_COUNT, 8'h55);
        wr(ADDR_CONTROL, 8'h00);
        repeat (5) @(posedge clk);
        rchk("stopped", ADDR_COUNT, 8'h55);
        // Every prescale code
        wr(ADDR_PERIOD, 8'hFF);
        for (n = 0; n < 4; n++) begin
            wr(ADDR_CONTROL, 8'h04 | n[7:0]);
            v = pwm_base.count;
            repeat (40) begin @(posedge clk); #1; if (pwm_base.count !== v) break; end
            v = pwm_base.count;
            repeat (n == 0 ? 1 : (n == 1 ? 4 : 16)) @(posedge clk);
            #1 chk("prescale", pwm_base.count, v + 8'h01);
        end
        // Every postscale code, counted in matches up to the interrupt
        wr(ADDR_PERIOD, 8'h01);
        wr(ADDR_ENABLES, 8'h02);
        for (n = 0; n < 16; n++) begin
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_FLAG_CLR, 8'h02);
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CONTROL, 8'h04 | 8'(n << 3));
            k = 0;
            repeat (60) begin #1; if (irq) break; k += tick; @(posedge clk); end
            chk("postscale", 8'(k), 8'(n + 1));
        end
        // Sticky flag, masking and clearing
        wr(ADDR_CONTROL, 8'h00);
        rchk("flags", ADDR_FLAGS, 8'h02);
        wr(ADDR_ENABLES, 8'h00);
        chk("irq_masked", {7'h00, irq}, 8'h00);
        wr(ADDR_ENABLES, 8'h02);
        chk("irq_enabled", {7'h00, irq}, 8'h01);
        wr(ADDR_FLAG_CLR, 8'h02);
        chk("irq_cleared", {7'h00, irq}, 8'h00);
        rchk("flags", ADDR_FLAGS, 8'h00);
        end_of_test;
    end
endmodule
